// ==== pkg/sercore_defines.svh ====
// sercore_defines.svh: register selectors, field positions and reset values
// assumes inclusion by the core modules only
`ifndef SERCORE_DEFINES_SVH
`define SERCORE_DEFINES_SVH

// register selectors on the command port
`define SER_SEL_STD_EVENT_ENABLE 4'h0
`define SER_SEL_SERVICE_REQ_ENABLE 4'h1
`define SER_SEL_PAR_POLL_ENABLE 4'h2
`define SER_SEL_INT_CHANGE_STATUS 4'h3
`define SER_SEL_INT_CHANGE_ENABLE 4'h4
`define SER_SEL_CMD_ERROR_CODE 4'h5
`define SER_SEL_HW_FAULT_STATUS 4'h6
`define SER_SEL_EXEC_ERROR_CODE 4'h7
`define SER_SEL_USER_BUTTON_CODE 4'h8
`define SER_SEL_INDIV_STATUS 4'h9
`define SER_SEL_STATUS_BYTE 4'ha
`define SER_SEL_STD_EVENT_STATUS 4'hb

// status byte positions
`define SER_SB_INTERNAL_CHANGE 0
`define SER_SB_EVENT_SUMMARY 5
`define SER_SB_MASTER_SUMMARY 6

// standard event positions
`define SER_EVT_QUERY_ERROR 2
`define SER_EVT_COMMAND_ERROR 5

// reset values
`define SER_RST_16 16'h0000
`define SER_RST_8 8'h00

`endif

// ==== pkg/sercore_pkg.sv ====
// sercore_pkg: types shared by the status reporting core
// assumes sercore_defines.svh is on the include path
package sercore_pkg;
   typedef enum logic [1:0] {
      SER_OP_IDLE,
      SER_OP_WRITE,
      SER_OP_QUERY,
      SER_OP_CLEAR_ALL
   } sercore_op_t;

   // one command or query message from the parser
   typedef struct packed {
      sercore_op_t op;
      logic [3:0] sel;
      logic [15:0] data;
   } sercore_req_t;

   // answer to a query, valid one cycle after the request
   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } sercore_rsp_t;

   // hardware event inputs, each valid for one cycle
   typedef struct packed {
      logic [15:0] int_change_set;
      logic cmd_error_valid;
      logic [15:0] cmd_error;
      logic [15:0] hw_fault_set;
      logic exec_error_valid;
      logic [15:0] exec_error;
      logic button_valid;
      logic [15:0] button;
   } sercore_evt_t;
endpackage

// ==== core/sercore_flagreg.sv ====
// sercore_flagreg: sticky flag bits with read-to-clear
// assumes clear and set pulses are synchronous to clk_sys
`timescale 1ns/100ps
`include "sercore_defines.svh"
module sercore_flagreg #(
   parameter int WIDTH = 16
)(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [WIDTH-1:0] set_bits,
   input wire logic clear,
   output logic [WIDTH-1:0] flags
);
   import sercore_pkg::*;
   logic [WIDTH-1:0] flags_r;
   logic [WIDTH-1:0] flags_nxt;

   // refused at elaboration: the set and clear paths serve a 1 to 16 bit word
   if (WIDTH < 1 || WIDTH > 16)
   begin
      $error("sercore_flagreg width out of range");
   end

   // a set in the clearing cycle survives the clear
   assign flags_nxt = (clear ? '0 : flags_r) | set_bits;
   assign flags = flags_r;

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         flags_r <= '0;
      else
         flags_r <= flags_nxt;
   end
endmodule

// ==== core/sercore_codereg.sv ====
// sercore_codereg: holds the most recent code, cleared by read
// assumes load and clear are synchronous to clk_sys
`timescale 1ns/100ps
`include "sercore_defines.svh"
module sercore_codereg #(
   parameter int WIDTH = 16
)(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic load,
   input wire logic [WIDTH-1:0] load_code,
   input wire logic clear,
   output logic [WIDTH-1:0] code
);
   import sercore_pkg::*;
   logic [WIDTH-1:0] code_r;
   logic [WIDTH-1:0] code_nxt;

   // refused at elaboration: codes are carried in a 1 to 16 bit word
   if (WIDTH < 1 || WIDTH > 16)
   begin
      $error("sercore_codereg width out of range");
   end

   // a new code arriving with the clear is kept
   assign code_nxt = load ? load_code : (clear ? '0 : code_r);
   assign code = code_r;

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         code_r <= '0;
      else
         code_r <= code_nxt;
   end
endmodule

// ==== core/sercore_status.sv ====
// sercore_status: status and service request reporting core
// assumes a parser that delivers decoded command and query messages, one per cycle,
// and hardware events as one-cycle pulses; all on clk_sys
`timescale 1ns/100ps
`include "sercore_defines.svh"

// How it works
// - event summary needs matching enable bit
// - event enable written, queried, cleared by zero
// - writing 4 enables query error reporting
// - eight-bit service mask gates service request
// - service mask written, queried, cleared by zero
// - poll mask gates individual status bit
// - poll mask written, queried, cleared by zero
// - poll mask stored as binary weights
// - sixteen internal change flags latch completions
// - change flags cleared by read or clear-all
// - change summary needs matching enable bit
// - change enable written, queried, cleared by zero
// - command error code read-to-clear
// - hardware fault bits read-to-clear
// - execution error code read-to-clear
// - button code read-to-clear
// - masks ANDed, results ORed into summaries
// - change summary bit 0, event summary bit 5
// - master summary from enabled status bits
// - nonzero command error sets event bit 5
module sercore_status (
   input wire logic clk_sys,
   input wire logic rst,
   input wire sercore_pkg::sercore_req_t req,
   input wire sercore_pkg::sercore_evt_t evt,
   input wire logic [15:0] std_event_in,
   input wire logic value_adapted,
   input wire logic message_available,
   output sercore_pkg::sercore_rsp_t rsp,
   output logic [7:0] status_byte,
   output logic service_request,
   output logic indiv_status,
   output logic event_summary_bit,
   output logic internal_change_summary_bit
);
   import sercore_pkg::*;

   logic [15:0] std_event_enable_r;
   logic [7:0] service_request_enable_r;
   logic [7:0] parallel_poll_enable_r;
   logic [15:0] internal_change_enable_r;
   logic [15:0] std_event_status_r;
   logic [15:0] std_event_status_nxt;
   sercore_rsp_t rsp_r;
   sercore_rsp_t rsp_nxt;
   logic [7:0] status_byte_r;
   logic service_request_r;
   logic indiv_status_r;

   wire is_write = (req.op == SER_OP_WRITE);
   wire is_query = (req.op == SER_OP_QUERY);
   wire clear_all = (req.op == SER_OP_CLEAR_ALL);
   wire wr_event_mask = is_write && (req.sel == `SER_SEL_STD_EVENT_ENABLE);
   wire wr_service_mask = is_write && (req.sel == `SER_SEL_SERVICE_REQ_ENABLE);
   wire wr_poll_mask = is_write && (req.sel == `SER_SEL_PAR_POLL_ENABLE);
   wire wr_change_mask = is_write && (req.sel == `SER_SEL_INT_CHANGE_ENABLE);
   wire rd_change_flags = is_query && (req.sel == `SER_SEL_INT_CHANGE_STATUS);
   wire rd_cmd_code = is_query && (req.sel == `SER_SEL_CMD_ERROR_CODE);
   wire rd_fault_flags = is_query && (req.sel == `SER_SEL_HW_FAULT_STATUS);
   wire rd_exec_code = is_query && (req.sel == `SER_SEL_EXEC_ERROR_CODE);
   wire rd_button_code = is_query && (req.sel == `SER_SEL_USER_BUTTON_CODE);
   wire rd_event_status = is_query && (req.sel == `SER_SEL_STD_EVENT_STATUS);

   logic [15:0] internal_change_status;
   logic [15:0] command_error_code;
   logic [15:0] hardware_fault_status;
   logic [15:0] execution_error_code;
   logic [15:0] user_button_code;

   sercore_flagreg #(.WIDTH(16)) u_change_flags (
      .clk_sys(clk_sys),
      .rst(rst),
      .set_bits(evt.int_change_set),
      .clear(rd_change_flags | clear_all),
      .flags(internal_change_status)
   );

   sercore_flagreg #(.WIDTH(16)) u_fault_flags (
      .clk_sys(clk_sys),
      .rst(rst),
      .set_bits(evt.hw_fault_set),
      .clear(rd_fault_flags | clear_all),
      .flags(hardware_fault_status)
   );

   sercore_codereg #(.WIDTH(16)) u_cmd_code (
      .clk_sys(clk_sys),
      .rst(rst),
      .load(evt.cmd_error_valid),
      .load_code(evt.cmd_error),
      .clear(rd_cmd_code | clear_all),
      .code(command_error_code)
   );

   sercore_codereg #(.WIDTH(16)) u_exec_code (
      .clk_sys(clk_sys),
      .rst(rst),
      .load(evt.exec_error_valid),
      .load_code(evt.exec_error),
      .clear(rd_exec_code | clear_all),
      .code(execution_error_code)
   );

   sercore_codereg #(.WIDTH(16)) u_button_code (
      .clk_sys(clk_sys),
      .rst(rst),
      .load(evt.button_valid),
      .load_code(evt.button),
      .clear(rd_button_code | clear_all),
      .code(user_button_code)
   );

   // a nonzero command error code holds its event bit set, so clearing the
   // event register while the code stays nonzero leaves that bit set, it never drops
   wire cmd_err_flag = (evt.cmd_error_valid && evt.cmd_error != 16'h0000)
      || (command_error_code != 16'h0000);
   logic [15:0] std_event_set;
   always_comb
   begin
      std_event_set = std_event_in;
      std_event_set[`SER_EVT_COMMAND_ERROR] = std_event_in[`SER_EVT_COMMAND_ERROR]
         | cmd_err_flag;
   end
   assign std_event_status_nxt = ((rd_event_status | clear_all) ? `SER_RST_16
      : std_event_status_r) | std_event_set;

   // summaries are combinational from the current registers, so a mask
   // write is visible one edge later in the registered outputs
   wire event_sum_now = |(std_event_status_r & std_event_enable_r);
   wire change_sum_now = |(internal_change_status & internal_change_enable_r);
   logic [7:0] status_base;
   always_comb
   begin
      status_base = 8'h00;
      status_base[`SER_SB_INTERNAL_CHANGE] = change_sum_now;
      status_base[2] = value_adapted;
      status_base[4] = message_available;
      status_base[`SER_SB_EVENT_SUMMARY] = event_sum_now;
   end
   wire master_sum_now = |(status_base & service_request_enable_r);
   wire ist_now = |(status_base & parallel_poll_enable_r);
   logic [7:0] status_full;
   always_comb
   begin
      status_full = status_base;
      status_full[`SER_SB_MASTER_SUMMARY] = master_sum_now;
   end

   // the master summary position is never stored in the service mask, so it
   // cannot feed back into itself through the mask
   logic [7:0] service_wdata;
   always_comb
   begin
      service_wdata = req.data[7:0];
      service_wdata[`SER_SB_MASTER_SUMMARY] = 1'b0;
   end

   always_comb
   begin
      rsp_nxt.valid = is_query;
      unique case (req.sel)
         `SER_SEL_STD_EVENT_ENABLE: rsp_nxt.data = std_event_enable_r;
         `SER_SEL_SERVICE_REQ_ENABLE: rsp_nxt.data = {8'h00, service_request_enable_r};
         `SER_SEL_PAR_POLL_ENABLE: rsp_nxt.data = {8'h00, parallel_poll_enable_r};
         `SER_SEL_INT_CHANGE_STATUS: rsp_nxt.data = internal_change_status;
         `SER_SEL_INT_CHANGE_ENABLE: rsp_nxt.data = internal_change_enable_r;
         `SER_SEL_CMD_ERROR_CODE: rsp_nxt.data = command_error_code;
         `SER_SEL_HW_FAULT_STATUS: rsp_nxt.data = hardware_fault_status;
         `SER_SEL_EXEC_ERROR_CODE: rsp_nxt.data = execution_error_code;
         `SER_SEL_USER_BUTTON_CODE: rsp_nxt.data = user_button_code;
         `SER_SEL_INDIV_STATUS: rsp_nxt.data = {15'h0000, ist_now};
         `SER_SEL_STATUS_BYTE: rsp_nxt.data = {8'h00, status_full};
         `SER_SEL_STD_EVENT_STATUS: rsp_nxt.data = std_event_status_r;
         default: rsp_nxt.data = 16'h0000;
      endcase
      if (!is_query)
      begin
         rsp_nxt.data = 16'h0000;
      end
   end

   // enable masks; a written number is stored as its binary weights
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         std_event_enable_r <= `SER_RST_16;
      else if (wr_event_mask)
         std_event_enable_r <= req.data;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         service_request_enable_r <= `SER_RST_8;
      else if (wr_service_mask)
         service_request_enable_r <= service_wdata;
   end

   // only the low byte is kept; upper data bits of a poll mask write are lost
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         parallel_poll_enable_r <= `SER_RST_8;
      else if (wr_poll_mask)
         parallel_poll_enable_r <= req.data[7:0];
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         internal_change_enable_r <= `SER_RST_16;
      else if (wr_change_mask)
         internal_change_enable_r <= req.data;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         std_event_status_r <= `SER_RST_16;
      else
         std_event_status_r <= std_event_status_nxt;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         rsp_r <= '0;
      else
         rsp_r <= rsp_nxt;
   end

   // outputs are registered so every pin comes from a flop; the cost is one
   // cycle between a cause and its summary
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         status_byte_r <= `SER_RST_8;
      else
         status_byte_r <= status_full;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         service_request_r <= 1'b0;
      else
         service_request_r <= master_sum_now;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         indiv_status_r <= 1'b0;
      else
         indiv_status_r <= ist_now;
   end

   assign rsp = rsp_r;
   assign status_byte = status_byte_r;
   assign service_request = service_request_r;
   assign indiv_status = indiv_status_r;
   assign event_summary_bit = status_byte_r[`SER_SB_EVENT_SUMMARY];
   assign internal_change_summary_bit = status_byte_r[`SER_SB_INTERNAL_CHANGE];
endmodule

// ==== bench/ser_status_assertions.sv ====
// ser_status_assertions: port timing checks for the status core
// assumes sercore_pkg compiled first; bound into sercore_status
`timescale 1ns/100ps
module ser_status_chk (
   input wire logic clk_sys,
   input wire logic rst,
   input wire sercore_pkg::sercore_req_t req,
   input wire sercore_pkg::sercore_evt_t evt,
   input wire sercore_pkg::sercore_rsp_t rsp,
   input wire logic [7:0] status_byte,
   input wire logic service_request,
   input wire logic indiv_status,
   input wire logic event_summary_bit,
   input wire logic internal_change_summary_bit
);
   import sercore_pkg::*;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   wire qy = (req.op == SER_OP_QUERY);
   wire clr = (req.op == SER_OP_CLEAR_ALL);
   wire wr = (req.op == SER_OP_WRITE);
   AST_RSP_VALID: assert property (qy |=> rsp.valid)
      else $error("query not answered");
   AST_RSP_NONE: assert property (!qy |=> !rsp.valid)
      else $error("answer without query");
   AST_SUM_COPY: assert property (event_summary_bit == status_byte[5]
      && internal_change_summary_bit == status_byte[0])
      else $error("summary copy differs");
   AST_SRQ_MASTER: assert property (service_request == status_byte[6])
      else $error("service request differs");
   AST_MASTER_CAUSE: assert property ($rose(status_byte[6])
      |-> |{status_byte[7], status_byte[5:0]})
      else $error("master summary without cause");
   AST_EVT_MASK_OFF: assert property (wr && req.sel == 4'h0 && req.data == 16'h0000
      |-> ##2 !status_byte[5])
      else $error("event summary with mask cleared");
   AST_SVC_MASK_OFF: assert property (wr && req.sel == 4'h1 && req.data == 16'h0000
      |-> ##2 !service_request)
      else $error("service request with mask cleared");
   AST_SVC_BIT6: assert property (qy && req.sel == 4'h1
      |=> !rsp.data[6] && rsp.data[15:8] == 8'h00)
      else $error("service mask bit 6 read set");
   AST_IST_BOOL: assert property (qy && req.sel == 4'h9
      |=> rsp.data[15:1] == 15'h0000)
      else $error("individual status not 0 or 1");
   AST_CHG_CLR: assert property ((qy && req.sel == 4'h3 || clr) && !(|evt.int_change_set)
      ##1 qy && req.sel == 4'h3 && !(|evt.int_change_set) |=> rsp.data == 16'h0000)
      else $error("change flags survived read");
   AST_CODE_CLR: assert property ((qy && req.sel == 4'h5 || clr) && !evt.cmd_error_valid
      ##1 qy && req.sel == 4'h5 && !evt.cmd_error_valid |=> rsp.data == 16'h0000)
      else $error("command code survived read");
   cover property (qy && req.sel == 4'h3 ##1 qy && req.sel == 4'h3);
   cover property ($rose(service_request));
   cover property ($rose(indiv_status));
endmodule
bind sercore_status ser_status_chk chk_u (.clk_sys(clk_sys), .rst(rst), .req(req),
   .evt(evt), .rsp(rsp), .status_byte(status_byte), .service_request(service_request),
   .indiv_status(indiv_status), .event_summary_bit(event_summary_bit),
   .internal_change_summary_bit(internal_change_summary_bit));

// ==== bench/ser_ctrl_model.sv ====
// ser_ctrl_model: remote controller, one decoded message per call
// assumes callers enter just after a rising edge of clk_sys
`timescale 1ns/100ps
module ser_ctrl_model (
   input wire logic clk_sys,
   output sercore_pkg::sercore_req_t req
);
   import sercore_pkg::*;
   initial req = '{SER_OP_IDLE, 4'h0, 16'h0000};
   // a message stays until the next call; idle inverts the payload so
   // nothing can lean on a stale selector or data word
   task automatic send(input sercore_op_t op, input logic [3:0] s, input logic [15:0] d);
      if (op == SER_OP_IDLE)
         req = '{op, ~req.sel, ~req.data};
      else
         req = '{op, s, d};
      @(posedge clk_sys);
      #1;
   endtask
endmodule

// ==== bench/tb_top.sv ====
// tb_top: self-checking bench for the status reporting core
// assumes sercore_pkg, the core files and the bench models are compiled
`timescale 1ns/100ps
module tb_top;
   import sercore_pkg::*;
   typedef struct {logic [3:0] s; logic [15:0] w; logic [15:0] r;} ser_row_t;
   logic clk_sys, rst, value_adapted, message_available, service_request, indiv_status;
   logic event_summary_bit, internal_change_summary_bit;
   logic [15:0] std_event_in;
   logic [7:0] status_byte;
   sercore_req_t req;
   sercore_evt_t evt, e;
   sercore_rsp_t rsp;
   int err_count, checks_done;
   ser_row_t rows[9] = '{'{4'h0, 16'h0004, 16'h0004}, '{4'h1, 16'h00ff, 16'h00bf},
      '{4'h1, 16'hff40, 16'h0000}, '{4'h2, 16'h0005, 16'h0005}, '{4'h4, 16'h8001, 16'h8001},
      '{4'h0, 16'h0000, 16'h0000}, '{4'h1, 16'h0000, 16'h0000}, '{4'h2, 16'h0000, 16'h0000},
      '{4'h4, 16'h0000, 16'h0000}};
   sercore_status dut_u (.clk_sys, .rst, .req, .evt, .std_event_in, .value_adapted,
      .message_available, .rsp, .status_byte, .service_request, .indiv_status,
      .event_summary_bit, .internal_change_summary_bit);
   ser_ctrl_model ctl_u (.clk_sys, .req);
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) ctl_u.send(SER_OP_IDLE, 4'h0, 16'h0000);
   endtask
   // the answer is read in the cycle after the query edge, where it stands
   task automatic q(input logic [3:0] s, input logic [15:0] x);
      ctl_u.send(SER_OP_QUERY, s, 16'h0000);
      chk("answer", (rsp.valid === 1'b1) ? rsp.data : 16'hdead, x);
   endtask
   task automatic ev(input sercore_evt_t x, input logic [15:0] s);
      evt = x;
      std_event_in = s;
      idle(1);
      evt = '0;
      std_event_in = 16'h0000;
      idle(3);
   endtask
   task automatic chk_status(input logic [7:0] x, input logic i);
      chk("status", {4'h0, internal_change_summary_bit, event_summary_bit, indiv_status,
         service_request, status_byte}, {4'h0, x[0], x[5], i, x[6], x});
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      #100000;
      $display("mismatch watchdog expected done seen hang");
      err_count++;
      tally_and_finish();
   end
   initial
   begin
      rst = 1'b1;
      evt = '0;
      e = '0;
      std_event_in = 16'h0000;
      value_adapted = 1'b0;
      message_available = 1'b0;
      err_count = 0;
      checks_done = 0;
      repeat (20) @(posedge clk_sys);
      #1 rst = 1'b0;
      idle(1);
      chk_status(8'h00, 1'b0);
      for (int i = 0; i < 12; i++)
         q(4'(i), 16'h0000);
      foreach (rows[i])
      begin
         ctl_u.send(SER_OP_WRITE, rows[i].s, rows[i].w);
         q(rows[i].s, rows[i].r);
      end
      value_adapted = 1'b1;
      message_available = 1'b1;
      ctl_u.send(SER_OP_WRITE, 4'h1, 16'h0010);
      idle(3);
      chk_status(8'h54, 1'b0);
      ctl_u.send(SER_OP_WRITE, 4'h1, 16'h0000);
      idle(3);
      chk_status(8'h14, 1'b0);
      value_adapted = 1'b0;
      message_available = 1'b0;
      e.cmd_error_valid = 1'b1;
      e.cmd_error = 16'h0001;
      ev(e, 16'h0000);
      chk_status(8'h00, 1'b0);
      ctl_u.send(SER_OP_WRITE, 4'h0, 16'h0020);
      idle(3);
      chk_status(8'h20, 1'b0);
      ctl_u.send(SER_OP_WRITE, 4'h1, 16'h0020);
      idle(3);
      chk_status(8'h60, 1'b0);
      q(4'h5, 16'h0001);
      q(4'h5, 16'h0000);
      ctl_u.send(SER_OP_CLEAR_ALL, 4'h0, 16'h0000);
      ctl_u.send(SER_OP_WRITE, 4'h0, 16'h0004);
      e = '0;
      ev(e, 16'h0004);
      chk_status(8'h60, 1'b0);
      q(4'ha, 16'h0060);
      ctl_u.send(SER_OP_WRITE, 4'h0, 16'h0000);
      idle(3);
      chk_status(8'h00, 1'b0);
      q(4'hb, 16'h0004);
      ctl_u.send(SER_OP_CLEAR_ALL, 4'h0, 16'h0000);
      ctl_u.send(SER_OP_WRITE, 4'h4, 16'h0001);
      ctl_u.send(SER_OP_WRITE, 4'h2, 16'h0001);
      e.int_change_set = 16'h8001;
      ev(e, 16'h0000);
      chk_status(8'h01, 1'b1);
      q(4'h9, 16'h0001);
      q(4'h3, 16'h8001);
      q(4'h3, 16'h0000);
      idle(3);
      chk_status(8'h00, 1'b0);
      q(4'h9, 16'h0000);
      e = '0;
      e.hw_fault_set = 16'h0011;
      e.exec_error_valid = 1'b1;
      e.exec_error = 16'h0003;
      ev(e, 16'h0000);
      e.hw_fault_set = 16'h0100;
      e.exec_error = 16'h0007;
      e.button_valid = 1'b1;
      e.button = 16'h000c;
      ev(e, 16'h0000);
      q(4'h6, 16'h0111);
      q(4'h7, 16'h0007);
      q(4'h8, 16'h000c);
      for (int i = 6; i < 9; i++)
         q(4'(i), 16'h0000);
      ev(e, 16'h0000);
      ctl_u.send(SER_OP_CLEAR_ALL, 4'h0, 16'h0000);
      for (int i = 6; i < 9; i++)
         q(4'(i), 16'h0000);
      // mid-run reset with the service, poll and change masks, the execution and button codes and the fault flags nonzero
      ev(e, 16'h0004);
      rst = 1'b1;
      idle(2);
      rst = 1'b0;
      chk_status(8'h00, 1'b0);
      for (int i = 0; i < 12; i++)
         q(4'(i), 16'h0000);
      tally_and_finish();
   end
endmodule
